// ---- rtl/acr_pkg.sv ----
package acr_pkg;

  // Register map. Printed offsets are not multiples of four, so they are indices.
  localparam logic [7:0] ACR_IDX_CSR  = 8'h34;
  localparam logic [7:0] ACR_IDX_DRH  = 8'h35;
  localparam logic [7:0] ACR_IDX_DRL  = 8'h36;
  localparam logic [7:0] ACR_IDX_IST  = 8'h37;
  localparam logic [7:0] ACR_IDX_IMSK = 8'h38;
  localparam logic [7:0] ACR_IDX_PWR  = 8'h39;
  localparam int         ACR_ADDR_W   = 12;

  // Control/status field positions.
  localparam int ACR_CSR_DONE  = 7;
  localparam int ACR_CSR_RATE  = 6;
  localparam int ACR_CSR_PWR   = 5;
  localparam logic [7:0] ACR_CSR_WMASK = 8'h67;

  // Amplifier control / low result field positions.
  localparam int ACR_DRL_CAL   = 4;
  localparam int ACR_DRL_QTR   = 3;
  localparam int ACR_DRL_GAIN  = 2;
  localparam logic [7:0] ACR_DRL_WMASK = 8'h1C;

  localparam logic [7:0] ACR_CSR_RST  = 8'h00;
  localparam logic [7:0] ACR_CFG_RST  = 8'h00;
  localparam logic [2:0] ACR_CH_LAST  = 3'h6;
  localparam int         ACR_RES_W    = 10;
  localparam int         ACR_CONV_CYC = 14;

  localparam logic [1:0] ACR_RESP_OK     = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACR_DIV1, ACR_DIV2, ACR_DIV4} acr_div_t;

  typedef struct packed {
    logic       power_on;
    logic [2:0] channel;
    logic       zero_cal;
    logic       gain_x8;
  } acr_analog_t;

endpackage

// ---- rtl/acr_sar.sv ----
`timescale 1ns/100ps
// Successive approximation sequencer, one bit decided per converter clock enable.
module acr_sar
  import acr_pkg::*;
#(
  parameter int RES_W    = ACR_RES_W,
  parameter int CONV_CYC = ACR_CONV_CYC
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control.
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic             cmp_above,
  // Trial code to the analogue DAC and result.
  output logic [RES_W-1:0]      trial,
  output logic [RES_W-1:0]      result,
  output logic                  done
);

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BITS} acr_sar_st_t;

  acr_sar_st_t      state_ff;
  logic [RES_W-1:0] code_ff;
  logic [RES_W-1:0] bit_ff;
  logic [4:0]       cnt_ff;

  assign trial = code_ff | bit_ff;

  // Sampling takes the cycles beyond one per bit, so a conversion lasts CONV_CYC ticks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SAR_IDLE;
      code_ff  <= '0;
      bit_ff   <= '0;
      cnt_ff   <= '0;
      result   <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!run) begin
        state_ff <= SAR_IDLE;
      end else if (tick) begin
        unique case (state_ff)
          SAR_IDLE: begin
            state_ff <= SAR_SAMPLE;
            cnt_ff   <= 5'(CONV_CYC - RES_W - 1);
          end
          SAR_SAMPLE: begin
            if (cnt_ff == '0) begin
              state_ff <= SAR_BITS;
              code_ff  <= '0;
              bit_ff   <= {1'b1, {(RES_W-1){1'b0}}};
            end else begin
              cnt_ff <= cnt_ff - 5'd1;
            end
          end
          SAR_BITS: begin
            if (cmp_above) code_ff <= code_ff | bit_ff;
            bit_ff <= bit_ff >> 1;
            if (bit_ff[0]) begin
              result   <= cmp_above ? (code_ff | bit_ff) : code_ff;
              done     <= 1'b1;
              state_ff <= SAR_SAMPLE;
              cnt_ff   <= 5'(CONV_CYC - RES_W - 1);
            end
          end
        endcase
      end
    end
  end

endmodule

// ---- rtl/acr_top.sv ----
`timescale 1ns/100ps
// Operation
// [R01] Done flag sets at conversion end, clears on high-result read.
// [R02] Control bit 7 read-only, other control bits read/write; here bits 4 and 3 are not writable and read zero.
// [R03] Power bit enables converter and amplifier together.
// [R04] Three-bit channel field selects inputs 0 to 6.
// [R05] Converter clock: /2, undivided, or /4 by the two select bits.
// [R06] High result register returns result bits 9 to 2.
// [R07] Low register returns result bits 1 and 0.
// [R08] Low register bits 7 to 5 always read zero.
// [R09] Calibrate bit forces amplifier input to zero volts.
// [R10] Gain bit inserts the x8 amplifier.
// [R11] Software keeps converter clock at most 2 MHz with amplifier on.
// [R12] Control and configuration reset to zero; results undefined.
// [R13] Powered converter converts selected channel continuously.
// [R14] Above reference gives all ones, below gives zero.
// [R15] Halt disables the converter; wait has no effect.
// [R16] Both result bytes load together with the done flag.
// [R17] Each conversion takes a fixed number of converter clocks.
module acr_top
  import acr_pkg::*;
#(
  parameter int CONV_CYC = ACR_CONV_CYC
) (
  // Clock and reset.
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET_N,
  // AXI4-Lite write address and data.
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [ACR_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  // AXI4-Lite write response.
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  output logic [1:0]                 S_AXI_BRESP,
  // AXI4-Lite read.
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  input  wire logic [ACR_ADDR_W-1:0] S_AXI_ARADDR,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  // Low-power mode from the system.
  input  wire logic                  HALT_MODE,
  // Analogue core: comparator in, controls and trial code out.
  input  wire logic                  CMP_ABOVE,
  output acr_analog_t                ANALOG_CTRL,
  output logic [ACR_RES_W-1:0]       TRIAL_CODE,
  // Interrupt.
  output logic                       IRQ
);

  logic [7:0]           csr_ff;
  logic [7:0]           cfg_ff;
  logic [ACR_RES_W-1:0] res_ff;
  logic [7:0]           ist_ff;
  logic [7:0]           imsk_ff;
  logic                 aw_ff, w_ff;
  logic [7:0]           awidx_ff;
  logic [7:0]           wdat_ff;
  logic                 wstb_ff;
  logic                 cmp_s1_ff, cmp_s2_ff, cmp_s3_ff, cmp_ff;
  logic                 cmp_ok;
  logic [1:0]           div_ff;
  logic                 tick;
  logic                 run;
  logic                 conv_done;
  logic [ACR_RES_W-1:0] sar_result;
  logic                 wr_go;
  logic                 rd_go;
  logic [7:0]           ridx;
  logic [7:0]           rbyte;
  logic                 rhit;
  logic                 whit;
  acr_div_t             div_sel;

  // Write channel: address and data accepted in either order, held until both arrive.
  assign S_AXI_AWREADY = !aw_ff && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_ff && !S_AXI_BVALID;
  assign wr_go         = aw_ff && w_ff && !S_AXI_BVALID;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_ff    <= 1'b0;
      w_ff     <= 1'b0;
      awidx_ff <= 8'h00;
      wdat_ff  <= 8'h00;
      wstb_ff  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ff    <= 1'b1;
        awidx_ff <= S_AXI_AWADDR[9:2];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ff    <= 1'b1;
        wdat_ff <= S_AXI_WDATA[7:0];
        wstb_ff <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff  <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (awidx_ff)
      ACR_IDX_CSR, ACR_IDX_DRH, ACR_IDX_DRL,
      ACR_IDX_IST, ACR_IDX_IMSK: whit = 1'b1;
      default:                   whit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= ACR_RESP_OK;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= whit ? ACR_RESP_OK : ACR_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data.
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;
  assign ridx          = S_AXI_ARADDR[9:2];

  always_comb begin
    rhit  = 1'b1;
    rbyte = 8'h00;
    unique case (ridx)
      ACR_IDX_CSR:  rbyte = csr_ff;
      // [R06] High result byte
      ACR_IDX_DRH:  rbyte = res_ff[ACR_RES_W-1 -: 8];
      // [R07] [R08] Low bits, zero top
      ACR_IDX_DRL:  rbyte = (cfg_ff & ACR_DRL_WMASK) | {6'h00, res_ff[1:0]};
      ACR_IDX_IST:  rbyte = ist_ff;
      ACR_IDX_IMSK: rbyte = imsk_ff;
      default:      rhit  = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= ACR_RESP_OK;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h00_0000, rbyte};
      S_AXI_RRESP  <= rhit ? ACR_RESP_OK : ACR_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Control register with the done flag; a new conversion beats a same-cycle read.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // [R12] Reset to zero
      csr_ff <= ACR_CSR_RST;
      cfg_ff <= ACR_CFG_RST;
    end else begin
      if (wr_go && wstb_ff && awidx_ff == ACR_IDX_CSR) begin
        // [R02] Bit 7 protected
        csr_ff[6:0] <= wdat_ff[6:0] & ACR_CSR_WMASK[6:0];
      end
      if (wr_go && wstb_ff && awidx_ff == ACR_IDX_DRL) begin
        cfg_ff <= wdat_ff & ACR_DRL_WMASK;
      end
      // [R01] Done set wins
      if (conv_done) begin
        csr_ff[ACR_CSR_DONE] <= 1'b1;
      end else if (rd_go && ridx == ACR_IDX_DRH) begin
        csr_ff[ACR_CSR_DONE] <= 1'b0;
      end
    end
  end

  // [R12] [R16] Results load with the flag
  always_ff @(posedge CORE_CLK) begin
    if (conv_done) begin
      res_ff <= sar_result;
    end
  end

  // Interrupt status: set by conversion end, cleared by writing one; set wins.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ist_ff  <= 8'h00;
      imsk_ff <= 8'h00;
    end else begin
      if (wr_go && wstb_ff && awidx_ff == ACR_IDX_IMSK) imsk_ff <= {7'h00, wdat_ff[0]};
      if (conv_done) begin
        ist_ff[0] <= 1'b1;
      end else if (wr_go && wstb_ff && awidx_ff == ACR_IDX_IST && wdat_ff[0]) begin
        ist_ff[0] <= 1'b0;
      end
    end
  end

  assign IRQ = |(ist_ff & imsk_ff);

  // Comparator crosses from the analogue side; a change counts once stages two and three agree.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      cmp_ff    <= 1'b0;
    end else begin
      cmp_s1_ff <= CMP_ABOVE;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      cmp_ff    <= cmp_ok;
    end
  end

  // Agreeing stages pass straight through, so a trial is judged four edges after it is set.
  assign cmp_ok = (cmp_s2_ff == cmp_s3_ff) ? cmp_s3_ff : cmp_ff;

  // [R05] Divider select
  always_comb begin
    if (cfg_ff[ACR_DRL_QTR])       div_sel = ACR_DIV4;
    else if (csr_ff[ACR_CSR_RATE]) div_sel = ACR_DIV1;
    else                           div_sel = ACR_DIV2;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= run ? div_ff + 2'h1 : 2'h0;
    end
  end

  always_comb begin
    unique case (div_sel)
      ACR_DIV1: tick = run;
      ACR_DIV2: tick = run && div_ff[0];
      ACR_DIV4: tick = run && (div_ff == 2'h3);
      default:  tick = 1'b0;
    endcase
  end

  // [R03] [R15] Power gated by halt
  assign run = csr_ff[ACR_CSR_PWR] && !HALT_MODE;

  // [R04] [R09] [R10] Analogue controls
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANALOG_CTRL <= '0;
    end else begin
      ANALOG_CTRL.power_on <= run;
      ANALOG_CTRL.channel  <= (csr_ff[2:0] > ACR_CH_LAST) ? ACR_CH_LAST : csr_ff[2:0];
      ANALOG_CTRL.zero_cal <= cfg_ff[ACR_DRL_CAL];
      ANALOG_CTRL.gain_x8  <= cfg_ff[ACR_DRL_GAIN];
    end
  end

  // [R13] [R14] [R17] Continuous conversion
  acr_sar #(
    .RES_W    (ACR_RES_W),
    .CONV_CYC (CONV_CYC)
  ) u_sar (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .run       (run),
    .tick      (tick),
    .cmp_above (cmp_ok),
    .trial     (TRIAL_CODE),
    .result    (sar_result),
    .done      (conv_done)
  );

  property p_done_read_clear;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (rd_go && ridx == ACR_IDX_DRH && !conv_done) |=> !csr_ff[ACR_CSR_DONE];
  endproperty
  a_done_read_clear: assert property (p_done_read_clear) else $error("done not cleared"); // [R01]

  property p_done_set;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      conv_done |=> csr_ff[ACR_CSR_DONE] && res_ff == $past(sar_result);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done or result not loaded"); // [R16]

  property p_bit7_ro;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (!conv_done && !(rd_go && ridx == ACR_IDX_DRH)) |=> !$rose(csr_ff[ACR_CSR_DONE]);
  endproperty
  a_bit7_ro: assert property (p_bit7_ro) else $error("done set without conversion"); // [R02]

  property p_power;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      !run |=> !ANALOG_CTRL.power_on ##0 !conv_done;
  endproperty
  a_power: assert property (p_power) else $error("converter active while off"); // [R03]

  property p_channel;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      ##1 ANALOG_CTRL.channel <= ACR_CH_LAST;
  endproperty
  a_channel: assert property (p_channel) else $error("channel out of range"); // [R04]

  property p_div4;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (tick && div_sel == ACR_DIV4 && $stable(div_sel)) |=> (!tick || div_sel != ACR_DIV4) [*3];
  endproperty
  a_div4: assert property (p_div4) else $error("quarter rate wrong"); // [R05]

  property p_div2;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (tick && div_sel == ACR_DIV2) |=> !tick || div_sel != ACR_DIV2;
  endproperty
  a_div2: assert property (p_div2) else $error("half rate wrong"); // [R05]

  property p_low_zero;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (rd_go && ridx == ACR_IDX_DRL) |=> S_AXI_RDATA[7:5] == 3'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low reserved bits set"); // [R08]

  property p_halt;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      HALT_MODE |-> !tick;
  endproperty
  a_halt: assert property (p_halt) else $error("conversion runs in halt"); // [R15]

  property p_conv_gap;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      conv_done |=> !conv_done [*8];
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversions too close"); // [R17]

  property p_cal;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      RESET_N |=> ANALOG_CTRL.zero_cal == $past(cfg_ff[ACR_DRL_CAL]);
  endproperty
  a_cal: assert property (p_cal) else $error("calibrate control not applied"); // [R09]

endmodule

// ---- dv/acr_amodel.sv ----
`timescale 1ns/100ps
// Behavioural input multiplexer, amplifier and comparator.
// Levels are in half-code steps, so an odd level 2c+1 converts to code c.
module acr_amodel
  import acr_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Controls, trial code and input levels.
  input  wire acr_analog_t ctrl,
  input  wire logic [9:0]  trial,
  input  wire logic [15:0] lvl [7],
  // Comparator.
  output logic             cmp_above
);
  int   vin;
  logic junk_ff = 1'h0;

  // An unpowered comparator gives nothing useful, so it toggles.
  always_ff @(posedge clk) begin
    junk_ff <= !junk_ff;
  end

  always_comb begin
    vin = (ctrl.channel > 3'h6) ? 0 : int'(lvl[ctrl.channel]);
    if (ctrl.zero_cal) begin
      vin = 0;
    end
    if (ctrl.gain_x8) begin
      vin = vin * 8;
    end
    // powered comparison, saturating at both references
    cmp_above = ctrl.power_on ? (vin > 2 * int'(trial)) : junk_ff;
  end
endmodule

// ---- dv/test_acr_top.sv ----
`timescale 1ns/100ps
module test_acr_top
  import acr_pkg::*;
;
  localparam int CONV = 14;
  logic        clk, rst_n, awv, wv, bry, arv, rry, halt, cmp, awr, wr_rdy, bv, arr, rv, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [9:0]  trial, prev;
  logic [7:0]  c, lo, hi;
  logic [15:0] lvl [7];
  acr_analog_t actl;
  int          n_errors, num_checks, per = 0, cyc = 0;
  int          dv [4] = '{2, 1, 4, 4};

  acr_top #(.CONV_CYC(CONV)) uut (
    .CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .HALT_MODE(halt),
    .CMP_ABOVE(cmp), .ANALOG_CTRL(actl), .TRIAL_CODE(trial), .IRQ(irq));

  acr_amodel model (.clk(clk), .ctrl(actl), .trial(trial), .lvl(lvl), .cmp_above(cmp));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = !clk;
  end

  // Conversion period: cycles between successive starts, seen as the first trial code.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= trial;
    if (trial === 10'h200 && prev !== 10'h200) begin
      per <= cyc + 1;
      cyc <= 0;
    end
  end

  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic fin;
    n = 0;
    fin = 1'h0;
    @(posedge clk);
    awv <= 1'h1;
    awa <= a;
    wv <= 1'h1;
    wd <= {24'h0, d};
    ws <= 4'hF;
    bry <= 1'h1;
    while (!fin) begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_rdy) wv <= 1'h0;
      if (bv && bry) begin
        fin = 1'h1;
        bry <= 1'h0;
        chk(br, er);
      end
      if (n > 50) begin
        n_errors++;
        test_done;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d, input logic [1:0] er);
    int   n;
    logic fin;
    n = 0;
    fin = 1'h0;
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rry <= 1'h1;
    while (!fin) begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'h0;
      if (rv && rry) begin
        fin = 1'h1;
        rry <= 1'h0;
        d = rdat[7:0];
        chk(rr, er);
        chk(rdat[31:8], 32'h0);
      end
      if (n > 50) begin
        n_errors++;
        test_done;
      end
    end
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(ad(ACR_IDX_CSR), c, ACR_RESP_OK);
      n++;
    end while (c[7] !== 1'h1 && n < 100);
    if (c[7] !== 1'h1) begin
      n_errors++;
      test_done;
    end
  endtask

  // Two discarded samples make sure the next one was converted wholly under new settings.
  task automatic sample;
    repeat (2) begin
      wait_done;
      rd(ad(ACR_IDX_DRH), c, ACR_RESP_OK);
    end
    wait_done;
    rd(ad(ACR_IDX_DRL), lo, ACR_RESP_OK);
    rd(ad(ACR_IDX_DRH), hi, ACR_RESP_OK);
  endtask

  initial begin
    {rst_n, awv, wv, bry, arv, rry, halt} = 7'h0;
    {awa, ara, wd, ws} = 60'h0;
    for (int i = 0; i < 7; i++) lvl[i] = 16'(i * 290 + 1);
    lvl[6] = 16'hFFFF;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rd(ad(ACR_IDX_CSR), c, ACR_RESP_OK);
    chk(c, 8'h00);
    rd(ad(ACR_IDX_DRL), c, ACR_RESP_OK);
    chk(c & 8'h1C, 8'h00);
    chk(irq, 1'h0);
    wr(ad(ACR_IDX_CSR), 8'hDF, ACR_RESP_OK);
    rd(ad(ACR_IDX_CSR), c, ACR_RESP_OK);
    chk(c, 8'h47);
    // Gain is only enabled while powered off, so the 2 MHz limit never applies.
    wr(ad(ACR_IDX_DRL), 8'hFF, ACR_RESP_OK);
    rd(ad(ACR_IDX_DRL), c, ACR_RESP_OK);
    chk(c & 8'hFC, 8'h1C);
    chk({actl.zero_cal, actl.gain_x8, actl.power_on}, 3'h6);
    wr(ad(ACR_IDX_DRL), 8'h08, ACR_RESP_OK);
    for (int i = 0; i < 7; i++) begin
      wr(ad(ACR_IDX_CSR), 8'h20 | 8'(i), ACR_RESP_OK);
      sample;
      chk({actl.power_on, actl.channel}, {1'h1, 3'(i)});
      chk({hi, lo[1:0]}, (i == 6) ? 10'h3FF : 10'(i * 145));
      rd(ad(ACR_IDX_CSR), c, ACR_RESP_OK);
      chk(c[7], 1'h0);
    end
    wr(ad(ACR_IDX_DRL), 8'h18, ACR_RESP_OK);
    sample;
    chk({hi, lo[1:0]}, 10'h000);
    for (int k = 0; k < 4; k++) begin
      // Zero calibration holds the comparator low, so fast rates time the sequencer alone.
      wr(ad(ACR_IDX_DRL), k[1] ? 8'h18 : 8'h10, ACR_RESP_OK);
      wr(ad(ACR_IDX_CSR), k[0] ? 8'h63 : 8'h23, ACR_RESP_OK);
      repeat (700) @(posedge clk);
      chk(per, CONV * dv[k]);
    end
    wr(ad(ACR_IDX_DRL), 8'h08, ACR_RESP_OK);
    @(posedge clk);
    halt <= 1'h1;
    rd(ad(ACR_IDX_DRH), c, ACR_RESP_OK);
    lo = 8'h00;
    repeat (40) begin
      rd(ad(ACR_IDX_CSR), c, ACR_RESP_OK);
      lo = lo | c;
    end
    chk(lo[7], 1'h0);
    @(posedge clk);
    halt <= 1'h0;
    wait_done;
    wr(ad(ACR_IDX_IMSK), 8'h01, ACR_RESP_OK);
    chk(irq, 1'h1);
    wr(ad(ACR_IDX_IMSK), 8'h00, ACR_RESP_OK);
    chk(irq, 1'h0);
    wr(ad(ACR_IDX_CSR), 8'h00, ACR_RESP_OK);
    wr(ad(ACR_IDX_IST), 8'h01, ACR_RESP_OK);
    rd(ad(ACR_IDX_IST), c, ACR_RESP_OK);
    chk(c[0], 1'h0);
    wr(ad(ACR_IDX_IMSK), 8'h01, ACR_RESP_OK);
    chk(irq, 1'h0);
    rd(ad(8'h3F), c, ACR_RESP_SLVERR);
    chk(c, 8'h00);
    wr(ad(8'h3F), 8'hFF, ACR_RESP_SLVERR);
    test_done;
  end
endmodule
